// >>> jcfb_top.sv
// Character bridge: a two-word slave port on one side, a sampled JTAG node link on the other.
// Assumes the link pins change slowly against the system clock (several clocks per link period).
`timescale 1ns/1ps
`default_nettype none
module jcfb_top
    import jcfb_pkg::*;
#(
    parameter int WR_DEPTH = DEF_DEPTH,
    parameter int RD_DEPTH = DEF_DEPTH,
    parameter int WR_THRESH = DEF_THRESH,
    parameter int RD_THRESH = DEF_THRESH,
    parameter bit WR_USE_REGS = 1'b0,
    parameter bit RD_USE_REGS = 1'b0,
    parameter int SIM_LEN = 0,
    parameter logic [8*SIM_MAX_CHARS-1:0] SIM_TEXT = '0,
    parameter bit SIM_INTERACTIVE = 1'b0
) (
    // System clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Slave port.
    input wire logic bus_addr,
    input wire logic bus_read,
    input wire logic bus_write,
    input wire logic [31:0] bus_wdata,
    output logic [31:0] bus_rdata,
    output logic bus_rvalid,
    // Interrupt request.
    output logic irq,
    // Link from the JTAG hub.
    input wire logic link_clock,
    input wire logic link_in_valid,
    input wire logic [7:0] link_in_data,
    output logic link_in_ready,
    output logic link_out_valid,
    output logic [7:0] link_out_data,
    input wire logic link_out_take
);

    // Pointer widths follow the depths; depths outside the legal set are not checked here.
    localparam int WAW = $clog2(WR_DEPTH);
    localparam int RAW = $clog2(RD_DEPTH);
    localparam logic [WAW:0] WR_FULL = (WAW + 1)'(WR_DEPTH);
    localparam logic [RAW:0] RD_FULL = (RAW + 1)'(RD_DEPTH);
    localparam logic [WAW:0] WR_TH = (WAW + 1)'(WR_THRESH);
    localparam logic [RAW:0] RD_TH = (RAW + 1)'(RD_THRESH);
    localparam logic [5:0] PRE_LEN = 6'(SIM_LEN);

    typedef struct packed {
        jcfb_phase_t phase;
        logic [5:0] pre_idx;
        logic [WAW-1:0] o_wp;
        logic [WAW-1:0] o_rp;
        logic [WAW:0] o_cnt;
        logic [RAW-1:0] i_wp;
        logic [RAW-1:0] i_rp;
        logic [RAW:0] i_cnt;
        logic rd_ie;
        logic wr_ie;
        logic irq;
        logic [31:0] rdata;
        logic rvalid;
        logic [LNK_W-1:0] s1;
        logic [LNK_W-1:0] s2;
        logic [LNK_W-1:0] s3;
        logic [LNK_W-1:0] filt;
        logic [2:0] rdy_seen;
        logic [2:0] val_seen;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [1:0] bcnt;
    } jcfb_state_t;

    jcfb_state_t st;
    jcfb_state_t nxt;

    logic o_push;
    logic o_pop;
    logic i_push;
    logic i_pop;
    logic [7:0] i_wdata;
    logic [7:0] o_q;
    logic [7:0] i_q;
    logic tck_rise;
    logic in_take;
    logic drain;
    logic rd_pend;
    logic wr_pend;
    logic [1:0] c;

    // Cuts a FIFO count or space, passed in as 17 bits, down to the 16-bit report field.
    function automatic logic [15:0] jcfb_field16(input logic [16:0] v);
        return v[15:0];
    endfunction

    // Next-state logic for the whole block.
    always_comb begin
        nxt = st;
        c = 2'h0;

        // Three-stage sampling; a bit changes only when stages two and three agree.
        nxt.s1 = {link_clock, link_in_valid, link_out_take, link_in_data};
        nxt.s2 = st.s1;
        nxt.s3 = st.s2;
        for (int i = 0; i < LNK_W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                nxt.filt[i] = st.s3[i];
            end
        end
        tck_rise = nxt.filt[LNK_TCK] & ~st.filt[LNK_TCK];
        // Ready and valid as the host saw them at its edge, delayed like the pins, so a
        // slot freed during the sampling delay cannot take a byte the host still holds.
        nxt.rdy_seen = {st.rdy_seen[1:0], st.bcnt != BUF_ENTRIES};
        nxt.val_seen = {st.val_seen[1:0], st.o_cnt != '0};

        // Outbound side: the bus fills, the link drains on its clock edges.
        o_pop = tck_rise && nxt.filt[LNK_TAKE] && st.val_seen[2] && st.o_cnt != '0;
        o_push = bus_write && bus_addr == ADDR_DATA && st.o_cnt != WR_FULL;

        // Inbound path: link byte into the skid buffer, buffer into the FIFO.
        in_take = tck_rise && nxt.filt[LNK_INV] && st.rdy_seen[2] && st.bcnt != BUF_ENTRIES;
        drain = 1'b0;
        i_push = 1'b0;
        i_wdata = st.b0;
        if (st.phase == PH_PRELOAD) begin
            // Preload runs only when a string is configured and no console is used.
            if (SIM_INTERACTIVE || st.pre_idx >= PRE_LEN) begin
                nxt.phase = PH_RUN;
            end else if (st.i_cnt != RD_FULL) begin
                i_push = 1'b1;
                i_wdata = SIM_TEXT[8*st.pre_idx +: 8];
                nxt.pre_idx = st.pre_idx + 6'h01;
            end
        end else if (st.bcnt != 2'h0 && st.i_cnt != RD_FULL) begin
            drain = 1'b1;
            i_push = 1'b1;
        end

        // The buffer keeps at most two bytes; ready drops while both are taken.
        c = st.bcnt;
        if (drain) begin
            nxt.b0 = st.b1;
            c = c - 2'h1;
        end
        if (in_take) begin
            if (c == 2'h0) begin
                nxt.b0 = nxt.filt[LNK_DATA_LSB +: 8];
            end else begin
                nxt.b1 = nxt.filt[LNK_DATA_LSB +: 8];
            end
            c = c + 2'h1;
        end
        nxt.bcnt = c;

        // Bus read of the data word pops one byte when one is waiting.
        i_pop = bus_read && bus_addr == ADDR_DATA && st.i_cnt != '0;

        // Pointer and count updates.
        if (o_push) begin
            nxt.o_wp = st.o_wp + WAW'(1);
        end
        if (o_pop) begin
            nxt.o_rp = st.o_rp + WAW'(1);
        end
        nxt.o_cnt = st.o_cnt + (WAW + 1)'(o_push) - (WAW + 1)'(o_pop);
        if (i_push) begin
            nxt.i_wp = st.i_wp + RAW'(1);
        end
        if (i_pop) begin
            nxt.i_rp = st.i_rp + RAW'(1);
        end
        nxt.i_cnt = st.i_cnt + (RAW + 1)'(i_push) - (RAW + 1)'(i_pop);

        // Interrupt causes, from the current counts.
        wr_pend = st.wr_ie && st.o_cnt <= WR_TH;
        rd_pend = st.rd_ie && (RD_FULL - st.i_cnt) <= RD_TH;
        nxt.irq = wr_pend || rd_pend;

        // Control word write steers the interrupt enables.
        if (bus_write && bus_addr == ADDR_CTRL) begin
            nxt.rd_ie = bus_wdata[CTRL_RIE_BIT];
            nxt.wr_ie = bus_wdata[CTRL_WIE_BIT];
        end

        // Read answers one cycle after the request, from a register.
        nxt.rvalid = bus_read;
        if (bus_read) begin
            nxt.rdata = 32'h0000_0000;
            if (bus_addr == ADDR_DATA) begin
                if (i_pop) begin
                    nxt.rdata[DATA_BYTE_LSB +: 8] = i_q;
                    nxt.rdata[DATA_VALID_BIT] = 1'b1;
                    nxt.rdata[DATA_COUNT_LSB +: 16] = jcfb_field16(17'(st.i_cnt - 1'b1));
                end
            end else begin
                nxt.rdata[CTRL_RIE_BIT] = st.rd_ie;
                nxt.rdata[CTRL_WIE_BIT] = st.wr_ie;
                nxt.rdata[CTRL_RPEND_BIT] = rd_pend;
                nxt.rdata[CTRL_WPEND_BIT] = wr_pend;
                nxt.rdata[CTRL_SPACE_LSB +: 16] = jcfb_field16(17'(WR_FULL - st.o_cnt));
            end
        end
    end

    // State register; reset empties both FIFOs and restarts the preload phase.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '0;
            st.phase <= PH_PRELOAD;
            st.rd_ie <= CTRL_RIE_RESET;
            st.wr_ie <= CTRL_WIE_RESET;
            st.rdy_seen <= '1; // Ready shows a free slot all through reset.
        end else begin
            st <= nxt;
        end
    end

    // Stores read at the next pointer, so the head byte is ready the cycle after a pop.
    jcfb_mem #(.DEPTH(WR_DEPTH), .AW(WAW), .USE_REGS(WR_USE_REGS)) u_out_mem (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(o_push),
        .wr_addr(st.o_wp),
        .wr_data(bus_wdata[7:0]),
        .rd_addr(nxt.o_rp),
        .rd_data(o_q)
    );

    jcfb_mem #(.DEPTH(RD_DEPTH), .AW(RAW), .USE_REGS(RD_USE_REGS)) u_in_mem (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(i_push),
        .wr_addr(st.i_wp),
        .wr_data(i_wdata),
        .rd_addr(nxt.i_rp),
        .rd_data(i_q)
    );

    // Outputs.
    assign bus_rdata = st.rdata;
    assign bus_rvalid = st.rvalid;
    assign irq = st.irq;
    assign link_in_ready = st.bcnt != BUF_ENTRIES; // Ready is the buffer's free slot.
    assign link_out_valid = st.o_cnt != '0;
    assign link_out_data = o_q;

    // Checks kept beside the logic.
    a_full_write_drop: assert property (@(posedge clock) disable iff (!rst_n)
        (bus_write && bus_addr == ADDR_DATA && st.o_cnt == WR_FULL && !o_pop)
        |=> (st.o_cnt == $past(st.o_cnt) && st.o_wp == $past(st.o_wp)))
        else $error("Write to full outbound FIFO changed its state.");

    a_out_push_count: assert property (@(posedge clock) disable iff (!rst_n)
        (o_push && !o_pop) |=> st.o_cnt == $past(st.o_cnt) + 1'b1)
        else $error("Outbound count did not grow on a write.");

    a_out_link_pop: assert property (@(posedge clock) disable iff (!rst_n)
        (o_pop && !o_push) |=> (st.o_cnt == $past(st.o_cnt) - 1'b1 && !$past(st.o_cnt == '0)))
        else $error("Outbound count did not fall on a link take.");

    a_in_fill_count: assert property (@(posedge clock) disable iff (!rst_n)
        (i_push && !i_pop) |=> st.i_cnt == $past(st.i_cnt) + 1'b1)
        else $error("Inbound count did not grow on a delivered byte.");

    a_wr_irq_level: assert property (@(posedge clock) disable iff (!rst_n)
        (st.wr_ie && st.o_cnt <= WR_TH) |=> irq)
        else $error("Outbound threshold reached without interrupt.");

    a_rd_irq_level: assert property (@(posedge clock) disable iff (!rst_n)
        (st.rd_ie && (RD_FULL - st.i_cnt) <= RD_TH) |=> irq)
        else $error("Inbound threshold reached without interrupt.");

    a_irq_has_cause: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(irq) |-> $past(wr_pend || rd_pend))
        else $error("Interrupt rose without an enabled cause.");

    a_data_read_byte: assert property (@(posedge clock) disable iff (!rst_n)
        i_pop |=> (bus_rvalid && bus_rdata[DATA_VALID_BIT] && bus_rdata[14:8] == 7'h00))
        else $error("Data word read did not return one flagged byte.");

    a_reset_empties: assert property (@(posedge clock)
        !rst_n |=> (st.o_cnt == '0 && st.i_cnt == '0 && st.bcnt == 2'h0 && !irq))
        else $error("Reset did not empty the FIFOs.");

    a_preload_step: assert property (@(posedge clock) disable iff (!rst_n)
        (st.phase == PH_PRELOAD && !SIM_INTERACTIVE && st.pre_idx < PRE_LEN
            && st.i_cnt != RD_FULL)
        |=> st.i_cnt == $past(st.i_cnt) + 1'b1 - (RAW + 1)'($past(i_pop)))
        else $error("Preload did not place its next character.");

    a_in_pop_count: assert property (@(posedge clock) disable iff (!rst_n)
        (i_pop && !i_push) |=> st.i_cnt == $past(st.i_cnt) - 1'b1)
        else $error("Inbound count did not fall on a data read.");

    a_read_answer: assert property (@(posedge clock) disable iff (!rst_n)
        bus_read |=> bus_rvalid)
        else $error("Read request got no answer one cycle on.");

    a_no_stray_answer: assert property (@(posedge clock) disable iff (!rst_n)
        !bus_read |=> !bus_rvalid)
        else $error("Read answer appeared without a request.");

    a_empty_read_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (bus_read && bus_addr == ADDR_DATA && st.i_cnt == '0) |=> bus_rdata == 32'h0000_0000)
        else $error("Read of the empty inbound FIFO returned data.");

    a_ctrl_enable_write: assert property (@(posedge clock) disable iff (!rst_n)
        (bus_write && bus_addr == ADDR_CTRL)
        |=> (st.rd_ie == $past(bus_wdata[CTRL_RIE_BIT])
            && st.wr_ie == $past(bus_wdata[CTRL_WIE_BIT])))
        else $error("Control write did not set the interrupt enables.");

    a_irq_no_cause: assert property (@(posedge clock) disable iff (!rst_n)
        !(wr_pend || rd_pend) |=> !irq)
        else $error("Interrupt stayed high with no enabled cause.");

    a_out_count_bound: assert property (@(posedge clock) disable iff (!rst_n)
        st.o_cnt <= WR_FULL)
        else $error("Outbound count exceeded the FIFO depth.");

    a_in_count_bound: assert property (@(posedge clock) disable iff (!rst_n)
        st.i_cnt <= RD_FULL)
        else $error("Inbound count exceeded the FIFO depth.");

    a_refused_link_byte: assert property (@(posedge clock) disable iff (!rst_n)
        (tck_rise && nxt.filt[LNK_INV] && !st.rdy_seen[2]) |=> st.bcnt <= $past(st.bcnt))
        else $error("A byte offered while not ready entered the buffer.");

endmodule
`default_nettype wire

// >>> jcfb_pkg.sv
// Shared constants and types for the character bridge between a bus port and a JTAG node.
// Assumes a single system clock domain on the bus side; the link is sampled, not clocked.
package jcfb_pkg;

    // Register word selects on the slave port.
    localparam logic ADDR_DATA = 1'h0;
    localparam logic ADDR_CTRL = 1'h1;

    // Data register field positions.
    localparam int DATA_BYTE_LSB = 0;
    localparam int DATA_VALID_BIT = 15;
    localparam int DATA_COUNT_LSB = 16;

    // Control register field positions.
    localparam int CTRL_RIE_BIT = 0;
    localparam int CTRL_WIE_BIT = 1;
    localparam int CTRL_RPEND_BIT = 8;
    localparam int CTRL_WPEND_BIT = 9;
    localparam int CTRL_SPACE_LSB = 16;

    // Reset values of the software controls.
    localparam logic CTRL_RIE_RESET = 1'h0;
    localparam logic CTRL_WIE_RESET = 1'h0;

    // Depth limits and recommended defaults.
    localparam int MIN_DEPTH = 8;
    localparam int MAX_DEPTH = 32768;
    localparam int DEF_DEPTH = 64;
    localparam int DEF_THRESH = 8;

    // Link sample vector layout: clock, inbound valid, outbound take, inbound byte.
    localparam int LNK_W = 11;
    localparam int LNK_TCK = 10;
    localparam int LNK_INV = 9;
    localparam int LNK_TAKE = 8;
    localparam int LNK_DATA_LSB = 0;

    // Inbound skid buffer size.
    localparam logic [1:0] BUF_ENTRIES = 2'h2;

    // Longest simulated preload string, in characters.
    localparam int SIM_MAX_CHARS = 32;

    // Start-up phase of the block.
    typedef enum logic {PH_PRELOAD, PH_RUN} jcfb_phase_t;

endpackage

// >>> jcfb_mem.sv
// Byte store for one FIFO of the bridge, with a registered read port.
// Assumes the caller keeps pointers in range; no reset on the array itself.
`timescale 1ns/1ps
`default_nettype none
module jcfb_mem
    import jcfb_pkg::*;
#(
    parameter int DEPTH = DEF_DEPTH,
    parameter int AW = 6,
    parameter bit USE_REGS = 1'b0
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Write port.
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read port.
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);

    logic [7:0] store [DEPTH];

    // Both builds hold the same words; only the resources used differ.
    generate
        if (USE_REGS) begin : g_regs
            for (genvar i = 0; i < DEPTH; i++) begin : g_word
                always_ff @(posedge clock) begin
                    if (wr_en && wr_addr == AW'(i)) begin
                        store[i] <= wr_data;
                    end
                end
            end
        end else begin : g_block
            always_ff @(posedge clock) begin
                if (wr_en) begin
                    store[wr_addr] <= wr_data;
                end
            end
        end
    endgenerate

    // A write to the word being read is passed straight through, so a freshly
    // written head byte is never shadowed by the stale one.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (wr_en && wr_addr == rd_addr) begin
            rd_data <= wr_data;
        end else begin
            rd_data <= store[rd_addr];
        end
    end

endmodule
`default_nettype wire

// >>> jcfb_host_model.sv
// Host end of the JTAG link: link clock, inbound bytes, outbound takes.
// Assumes the bridge samples these pins with a clock several times faster.
`timescale 1ns/1ps
`default_nettype none
module jcfb_host_model (
    // Link pins.
    output logic link_clock,
    output logic link_in_valid,
    output logic [7:0] link_in_data,
    input wire logic link_in_ready,
    input wire logic link_out_valid,
    input wire logic [7:0] link_out_data,
    output logic link_out_take,
    // Bench controls.
    input wire logic run,
    input wire logic take_en
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];

    // Pins start idle.
    initial begin
        link_clock = 1'b0;
        link_in_valid = 1'b0;
        link_in_data = 8'h00;
        link_out_take = 1'b0;
    end

    // The link clock stands still between bursts and always stops low.
    always #80 if (run || link_clock) link_clock = ~link_clock;

    // A byte counts as sent only if the node had room at the rise, else it is offered again.
    always @(posedge link_clock) begin
        if (link_in_valid && link_in_ready && tx_q.size() != 0) tx_q.delete(0);
        if (link_out_take && link_out_valid) rx_q.push_back(link_out_data);
    end

    // New values go out at the fall, half a period ahead of the next rise.
    always @(negedge link_clock) begin
        link_in_valid = (tx_q.size() != 0);
        link_in_data = link_in_valid ? tx_q[0] : ~link_in_data; // Idle line keeps toggling.
        link_out_take = take_en;
    end
endmodule
`default_nettype wire

// >>> tb_jtag_character_fifo_bridge.sv
// Self-checking bench for the character bridge, built with small FIFOs.
// Assumes the host model owns the link and the bench owns the slave port.
`timescale 1ns/1ps
`default_nettype none
module tb_jtag_character_fifo_bridge;
    import jcfb_pkg::*;
    localparam int DEPTH = 8;
    localparam int THRESH = 2;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic bus_addr = 1'b0;
    logic bus_read = 1'b0;
    logic bus_write = 1'b0;
    logic [31:0] bus_wdata = 32'h0;
    logic [31:0] bus_rdata;
    logic bus_rvalid, irq, link_clock, link_in_valid, link_in_ready;
    logic link_out_valid, link_out_take, run, take_en;
    logic [7:0] link_in_data, link_out_data;
    logic [31:0] rd;
    logic [31:0] pre_rdata;
    int miscompares = 0;
    int total_checks = 0;

    jcfb_top #(.WR_DEPTH(DEPTH), .RD_DEPTH(DEPTH), .WR_THRESH(THRESH), .RD_THRESH(THRESH)) dut (
        .clock(clock), .rst_n(rst_n), .bus_addr(bus_addr), .bus_read(bus_read),
        .bus_write(bus_write), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_rvalid(bus_rvalid), .irq(irq), .link_clock(link_clock),
        .link_in_valid(link_in_valid), .link_in_data(link_in_data),
        .link_in_ready(link_in_ready), .link_out_valid(link_out_valid),
        .link_out_data(link_out_data), .link_out_take(link_out_take));

    jcfb_host_model host (
        .link_clock(link_clock), .link_in_valid(link_in_valid), .link_in_data(link_in_data),
        .link_in_ready(link_in_ready), .link_out_valid(link_out_valid),
        .link_out_data(link_out_data), .link_out_take(link_out_take),
        .run(run), .take_en(take_en));

    // A second build with register stores and a two-character preset; it shares all inputs.
    jcfb_top #(.WR_DEPTH(DEPTH), .RD_DEPTH(DEPTH), .WR_USE_REGS(1'b1), .RD_USE_REGS(1'b1),
        .SIM_LEN(2), .SIM_TEXT(256'h4241)) dut_pre (
        .clock(clock), .rst_n(rst_n), .bus_addr(bus_addr), .bus_read(bus_read),
        .bus_write(bus_write), .bus_wdata(bus_wdata), .bus_rdata(pre_rdata),
        .bus_rvalid(), .irq(), .link_clock(link_clock), .link_in_valid(link_in_valid),
        .link_in_data(link_in_data), .link_in_ready(), .link_out_valid(),
        .link_out_data(), .link_out_take(link_out_take));

    // System clock at 50 MHz.
    always #10 clock = ~clock;

    // Compare and count.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Print the verdict and stop.
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One read; the answer is registered, so it is looked at one cycle on.
    task automatic bus_rd(input logic addr, output logic [31:0] data);
        @(negedge clock);
        bus_addr = addr;
        bus_read = 1'b1;
        @(negedge clock);
        bus_read = 1'b0;
        check({31'h0, bus_rvalid}, 32'h1, "read answer");
        data = bus_rdata;
    endtask

    // Back-to-back writes; the strobe stays high for the whole burst.
    task automatic bus_wr(input logic addr, input logic [31:0] first, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            bus_addr = addr;
            bus_write = 1'b1;
            bus_wdata = first + 32'(i);
        end
        @(negedge clock);
        bus_write = 1'b0;
    endtask

    // Bounded wait for the host to collect n bytes.
    task automatic wait_rx(input int n);
        for (int i = 0; i < 2000 && host.rx_q.size() < n; i++) @(negedge clock);
    endtask

    task automatic test_reset;
        check(bus_rdata, 32'h0, "rdata at reset");
        check({29'h0, irq, link_in_ready, link_out_valid}, 32'h2, "flags at reset");
        bus_rd(ADDR_CTRL, rd);
        check(rd & 32'hffff0003, 32'(DEPTH) << CTRL_SPACE_LSB, "space at reset");
        bus_rd(ADDR_DATA, rd);
        check(rd, 32'h0, "read of empty FIFO");
        check(pre_rdata, (32'h1 << DATA_COUNT_LSB) | (32'h1 << DATA_VALID_BIT) | 32'h41,
            "preset char");
        $display("test_reset done");
    endtask

    task automatic test_outbound;
        bus_wr(ADDR_DATA, 32'hffffff30, DEPTH + 1);
        bus_rd(ADDR_CTRL, rd);
        check(rd >> CTRL_SPACE_LSB, 32'h0, "no space when full");
        bus_wr(ADDR_CTRL, 32'h2, 1);
        repeat (2) @(negedge clock);
        check({31'h0, irq}, 32'h0, "irq above threshold");
        take_en = 1'b1;
        run = 1'b1;
        wait_rx(DEPTH - THRESH - 1);
        repeat (7) @(negedge clock);
        check({31'h0, irq}, 32'h0, "irq one above threshold");
        wait_rx(DEPTH - THRESH);
        repeat (7) @(negedge clock);
        check({31'h0, irq}, 32'h1, "irq at threshold");
        bus_rd(ADDR_CTRL, rd);
        check((rd >> CTRL_WPEND_BIT) & 32'h1, 32'h1, "write pending");
        wait_rx(DEPTH);
        repeat (24) @(negedge clock);
        check(32'(host.rx_q.size()), 32'(DEPTH), "dropped byte stays out");
        for (int i = 0; i < DEPTH; i++) check(32'(host.rx_q[i]), 32'h30 + 32'(i), "order");
        check({31'h0, link_out_valid}, 32'h0, "outbound drained");
        run = 1'b0;
        take_en = 1'b0;
        bus_wr(ADDR_CTRL, 32'h0, 1);
        repeat (2) @(negedge clock);
        check({31'h0, irq}, 32'h0, "irq disabled");
        $display("test_outbound done");
    endtask

    task automatic test_inbound;
        for (int i = 0; i < DEPTH + 4; i++) host.tx_q.push_back(8'h60 + 8'(i));
        run = 1'b1;
        for (int i = 0; i < 3000 && host.tx_q.size() > 2; i++) @(negedge clock);
        repeat (40) @(negedge clock);
        check(32'(host.tx_q.size()), 32'h2, "bytes held back");
        check({31'h0, link_in_ready}, 32'h0, "ready low when full");
        bus_wr(ADDR_CTRL, 32'h1, 1);
        repeat (2) @(negedge clock);
        check({31'h0, irq}, 32'h1, "irq on inbound threshold");
        bus_rd(ADDR_CTRL, rd);
        check((rd >> CTRL_RPEND_BIT) & 32'h1, 32'h1, "read pending");
        for (int i = 0; i < DEPTH + 4; i++) begin
            bus_rd(ADDR_DATA, rd);
            check(rd & 32'h0000ffff, 32'h8060 + 32'(i), "inbound byte");
            if (i == 0) check(rd >> DATA_COUNT_LSB, 32'(DEPTH - 1), "bytes left");
            repeat (12) @(negedge clock);
        end
        check({31'h0, irq}, 32'h0, "irq clears when drained");
        bus_rd(ADDR_DATA, rd);
        check(rd, 32'h0, "read of empty FIFO");
        run = 1'b0;
        $display("test_inbound done");
    endtask

    task automatic test_midreset;
        bus_wr(ADDR_DATA, 32'h41, 3);
        @(negedge clock);
        rst_n = 1'b0;
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        check({30'h0, irq, link_out_valid}, 32'h0, "outbound empty after reset");
        bus_rd(ADDR_CTRL, rd);
        check(rd & 32'hffff0003, 32'(DEPTH) << CTRL_SPACE_LSB, "space after reset");
        $display("test_midreset done");
    endtask

    // Main sequence; reset is held for four cycles.
    initial begin
        run = 1'b0;
        take_en = 1'b0;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        test_reset;
        test_outbound;
        test_inbound;
        test_midreset;
        test_done;
    end

    // Watchdog, far beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        test_done;
    end
endmodule
`default_nettype wire
